// [src/mliet_regs.sv]
// serial-command register bank: interface config, interrupt config and ecc test
`timescale 1ns/1ps

// Contract
// - interface config bit 4 blocks execute-in-place writes when one; resets to zero.
// - read wait cycles field sets latency before read-any-register data, 0 to 15.
// - interrupt pin goes low on ecc detection or busy-to-ready, per configuration.
// - interrupt config bit 7 reads one after an unrecoverable error, resets zero.
// - writing one to bit 6 clears the unrecoverable interrupt; zero does nothing.
// - writing one to bit 5 zeroes the error tally; zero does nothing.
// - interrupt config bit 1 enables ecc test mode; resets to zero.
// - bit 0 lets ecc detection pull the interrupt pin low; zero leaves it.
// - interrupt config selects one of four dies; test mode uses the test bit alone, not the die.
// - 32-bit test input word, reset zero, feeds the engine data buffer.
// - flip mask is xored onto the buffer before the engine decodes it.
// - engine result shows in a 32-bit read-only word, reset zero.
// - 32-bit tally counts induced uncorrectable errors in test mode, reset zero.
// - in test mode an induced unrecoverable error sets the flag and the interrupt pin; the external one is ignored.
// - interface config bits 7 to 5 read zero.
// - register writes need the write enable latch, which a write clears.
module mliet_regs
    import mliet_pkg::*;
#(
    parameter bit READY_IRQ_EN = 1'b1
)(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic ecc_corrected_i,
    input wire logic ecc_uncorrectable_i,
    input wire logic dev_ready_i,
    output logic int_n_o,
    output logic execute_in_place_write_block_o,
    output logic [LAT_W-1:0] read_wait_cycles_o,
    output logic ecc_selftest_on_o,
    output logic [1:0] die_select_o,
    output logic write_enable_latch_o
);

    // ==========================================================
    // serial clock domain reset, asserted at once, released on sck
    logic rst_sck_meta_r;
    logic rst_sck_r;

    always_ff @(posedge sck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_sck_meta_r <= 1'b1;
            rst_sck_r <= 1'b1;
        end else begin
            rst_sck_meta_r <= 1'b0;
            rst_sck_r <= rst_sck_meta_r;
        end
    end

    // ==========================================================
    // frame decoder, cleared by chip select going high
    logic [6:0] bit_cnt_r;
    logic [6:0] sh_r;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [7:0] in_byte;
    logic [23:0] in_addr;

    assign in_byte = {sh_r, si_i};
    assign in_addr = {addr_r[22:0], si_i};

    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_r <= 7'h00;
            sh_r <= 7'h00;
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
        end else begin
            if (bit_cnt_r != BIT_CNT_MAX) begin
                bit_cnt_r <= bit_cnt_r + 7'h01;
            end
            sh_r <= in_byte[6:0];
            if (bit_cnt_r == CMD_LAST) begin
                cmd_r <= in_byte;
            end
            if ((bit_cnt_r > CMD_LAST) && (bit_cnt_r <= ADDR_LAST)) begin
                addr_r <= in_addr;
            end
        end
    end

    // ==========================================================
    // command events toward the core: 0 enable, 1 disable, 2 write, 3 read
    logic [3:0] tgl_r;
    mliet_wr_type wr_q_r;
    logic [23:0] rd_addr_r;
    logic ev_write_enable_latch_s;
    logic ev_wrdi_s;
    logic ev_wr_s;
    logic ev_rd_s;

    assign ev_write_enable_latch_s = (bit_cnt_r == CMD_LAST) && (in_byte == CMD_WRITE_ENABLE_LATCH);
    assign ev_wrdi_s = (bit_cnt_r == CMD_LAST) && (in_byte == CMD_WRDI);
    assign ev_wr_s = (bit_cnt_r == WDATA_LAST) && (cmd_r == CMD_WRAR);
    assign ev_rd_s = (bit_cnt_r == ADDR_LAST) && (cmd_r == CMD_RDAR);

    always_ff @(posedge sck_i or posedge rst_sck_r) begin
        if (rst_sck_r) begin
            tgl_r <= 4'h0;
            wr_q_r <= '0;
            rd_addr_r <= 24'h000000;
        end else begin
            tgl_r <= tgl_r ^ {ev_rd_s, ev_wr_s, ev_wrdi_s, ev_write_enable_latch_s};
            if (ev_wr_s) begin
                wr_q_r <= '{addr: addr_r, data: in_byte};
            end
            if (ev_rd_s) begin
                rd_addr_r <= in_addr;
            end
        end
    end

    // ==========================================================
    // latency and read acknowledge brought into the serial domain
    logic [LAT_W-1:0] ifc_lat_w;
    logic [LAT_W-1:0] lat_s1_r;
    logic [LAT_W-1:0] lat_s2_r;
    logic ack_tgl_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic [7:0] rd_byte_r;

    always_ff @(posedge sck_i or posedge rst_sck_r) begin
        if (rst_sck_r) begin
            lat_s1_r <= IFC_CFG_RST[IFC_LAT_MSB:0];
            lat_s2_r <= IFC_CFG_RST[IFC_LAT_MSB:0];
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            lat_s1_r <= ifc_lat_w;
            lat_s2_r <= lat_s1_r;
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // ==========================================================
    // read data out on the falling edge, after the wait cycles
    logic [6:0] data_start;
    logic [6:0] data_idx;
    logic rd_win;
    logic rd_bit;

    assign data_start = ADDR_END + {3'b000, lat_s2_r};
    assign data_idx = bit_cnt_r - data_start;
    assign rd_win = (cmd_r == CMD_RDAR) && (bit_cnt_r >= data_start) && (data_idx < BYTE_BITS);
    assign rd_bit = (ack_s2_r == tgl_r[3]) ? rd_byte_r[3'h7 - data_idx[2:0]] : 1'b0;

    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_o <= rd_win ? rd_bit : 1'b0;
            so_oe_o <= rd_win;
        end
    end

    // ==========================================================
    // core domain: event synchronisers and edge detection
    logic [3:0] tgl_s1_r;
    logic [3:0] tgl_s2_r;
    logic [3:0] tgl_seen_r;
    logic [3:0] ev_w;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_evsync
            always_ff @(posedge core_clk_i) begin
                if (sys_rst_i) begin
                    tgl_s1_r[g] <= 1'b0;
                    tgl_s2_r[g] <= 1'b0;
                    tgl_seen_r[g] <= 1'b0;
                end else begin
                    tgl_s1_r[g] <= tgl_r[g];
                    tgl_s2_r[g] <= tgl_s1_r[g];
                    tgl_seen_r[g] <= tgl_s2_r[g];
                end
            end
            assign ev_w[g] = tgl_s2_r[g] ^ tgl_seen_r[g];
        end
    endgenerate

    // ==========================================================
    // core registers and write decode
    logic [4:0] ifc_cfg_r;
    logic [3:0] int_cfg_r;
    logic flag_r;
    logic detect_r;
    logic [31:0] din_r;
    logic [31:0] mask_r;
    logic [31:0] result_r;
    logic [31:0] tally_r;
    logic wel_r;
    logic int_n_r;
    logic run_r;
    logic ready_d_r;

    logic wr_go;
    logic [1:0] wr_lane;
    logic hit_ifc;
    logic hit_int;
    logic hit_din;
    logic hit_mask;
    logic irq_clr;
    logic tally_clr;
    logic test_on;
    logic run_go;
    logic [31:0] din_nxt;
    logic [31:0] mask_nxt;

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[{lane, 3'b000} +: 8] = b;
        return r;
    endfunction : put_byte

    assign wr_go = ev_w[2] && wel_r;
    assign wr_lane = wr_q_r.addr[1:0];
    assign hit_ifc = wr_q_r.addr == ADDR_IFC_CFG;
    assign hit_int = wr_q_r.addr == ADDR_INT_CFG;
    assign hit_din = wr_q_r.addr[23:2] == ADDR_ECC_DIN[23:2];
    assign hit_mask = wr_q_r.addr[23:2] == ADDR_ECC_MASK[23:2];
    assign irq_clr = wr_go && hit_int && wr_q_r.data[INT_IRQ_CLR_BIT];
    assign tally_clr = wr_go && hit_int && wr_q_r.data[INT_TALLY_CLR_BIT];
    assign test_on = int_cfg_r[INT_TEST_BIT];
    // a config write runs the engine on the test bit it writes, not the old one
    assign run_go = hit_int ? wr_q_r.data[INT_TEST_BIT] : (test_on && (hit_din || hit_mask));
    assign din_nxt = put_byte(din_r, wr_lane, wr_q_r.data);
    assign mask_nxt = put_byte(mask_r, wr_lane, wr_q_r.data);
    assign ifc_lat_w = ifc_cfg_r[IFC_LAT_MSB:0];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ifc_cfg_r <= IFC_CFG_RST;
            int_cfg_r <= INT_CFG_RST;
            din_r <= WORD_RST;
            mask_r <= WORD_RST;
        end else if (wr_go) begin
            if (hit_ifc) begin
                ifc_cfg_r <= wr_q_r.data[IFC_XIP_BIT:0];
            end else if (hit_int) begin
                int_cfg_r <= wr_q_r.data[INT_DIE_MSB:0];
            end else if (hit_din) begin
                din_r <= din_nxt;
            end else if (hit_mask) begin
                mask_r <= mask_nxt;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wel_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            wel_r <= (wel_r || ev_w[0]) && !ev_w[1] && !ev_w[2];
            run_r <= wr_go && run_go;
        end
    end

    // ==========================================================
    // ecc test engine
    mliet_ecc_res_type eng_res;
    logic eng_done;

    mliet_ecc_engine u_engine (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(run_r),
        .data_i(din_r),
        .mask_i(mask_r),
        .res_o(eng_res),
        .done_o(eng_done)
    );

    // ==========================================================
    // events, flag, tally and interrupt pin
    logic unrec_ev;
    logic corr_ev;
    logic ready_ev;
    logic tally_inc;
    logic flag_nxt;
    logic detect_nxt;

    assign tally_inc = eng_done && eng_res.uncorrectable && test_on;
    assign unrec_ev = tally_inc || (!test_on && ecc_uncorrectable_i);
    assign corr_ev = int_cfg_r[INT_ROUTE_BIT] &&
                     ((eng_done && eng_res.corrected) || ecc_corrected_i);
    assign ready_ev = READY_IRQ_EN && dev_ready_i && !ready_d_r;
    assign flag_nxt = unrec_ev || (flag_r && !irq_clr);
    assign detect_nxt = corr_ev || ready_ev || (detect_r && !irq_clr);

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            flag_r <= 1'b0;
            detect_r <= 1'b0;
            int_n_r <= 1'b1;
            ready_d_r <= 1'b1;
            result_r <= WORD_RST;
            tally_r <= WORD_RST;
        end else begin
            flag_r <= flag_nxt;
            detect_r <= detect_nxt;
            int_n_r <= !(flag_nxt || detect_nxt);
            ready_d_r <= dev_ready_i;
            if (eng_done) begin
                result_r <= eng_res.word;
            end
            tally_r <= (tally_clr ? WORD_RST : tally_r) + {31'h00000000, tally_inc};
        end
    end

    // ==========================================================
    // read decode, answered back through a toggle
    logic [1:0] rd_lane;
    logic [7:0] ifc_rd;
    logic [7:0] int_rd;
    logic [31:0] word_rd;
    logic word_hit;
    logic [7:0] rd_mux;

    assign rd_lane = rd_addr_r[1:0];
    assign ifc_rd = {3'b000, ifc_cfg_r};
    assign int_rd = {flag_r, 3'b000, int_cfg_r};
    assign word_hit = (rd_addr_r[23:4] == ADDR_ECC_DIN[23:4]);
    assign word_rd = (rd_addr_r[3:2] == ADDR_ECC_DIN[3:2]) ? din_r :
                     (rd_addr_r[3:2] == ADDR_ECC_MASK[3:2]) ? mask_r :
                     (rd_addr_r[3:2] == ADDR_ECC_OUT[3:2]) ? result_r : tally_r;
    assign rd_mux = (rd_addr_r == ADDR_IFC_CFG) ? ifc_rd :
                    (rd_addr_r == ADDR_INT_CFG) ? int_rd :
                    word_hit ? word_rd[{rd_lane, 3'b000} +: 8] : 8'h00;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_byte_r <= 8'h00;
            ack_tgl_r <= 1'b0;
        end else if (ev_w[3]) begin
            rd_byte_r <= rd_mux;
            ack_tgl_r <= !ack_tgl_r;
        end
    end

    // ==========================================================
    // outputs
    assign int_n_o = int_n_r;
    assign execute_in_place_write_block_o = ifc_cfg_r[IFC_XIP_BIT];
    assign read_wait_cycles_o = ifc_cfg_r[IFC_LAT_MSB:0];
    assign ecc_selftest_on_o = int_cfg_r[INT_TEST_BIT];
    assign die_select_o = int_cfg_r[INT_DIE_MSB:INT_DIE_LSB];
    assign write_enable_latch_o = wel_r;

endmodule : mliet_regs

// [src/mliet_pkg.sv]
// package for the configuration, interrupt and ecc test register bank
package mliet_pkg;

    // ==========================================================
    // serial commands
    localparam logic [7:0] CMD_WRITE_ENABLE_LATCH = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_WRAR = 8'h71;
    localparam logic [7:0] CMD_RDAR = 8'h65;

    // ==========================================================
    // frame positions, counted in rising serial clock edges
    localparam logic [6:0] CMD_LAST = 7'h07;
    localparam logic [6:0] ADDR_LAST = 7'h1f;
    localparam logic [6:0] ADDR_END = 7'h20;
    localparam logic [6:0] WDATA_LAST = 7'h27;
    localparam logic [6:0] BIT_CNT_MAX = 7'h7f;
    localparam logic [6:0] BYTE_BITS = 7'h08;

    // ==========================================================
    // register addresses
    localparam logic [23:0] ADDR_IFC_CFG = 24'h000003;
    localparam logic [23:0] ADDR_INT_CFG = 24'h000004;
    localparam logic [23:0] ADDR_ECC_DIN = 24'h000010;
    localparam logic [23:0] ADDR_ECC_MASK = 24'h000014;
    localparam logic [23:0] ADDR_ECC_OUT = 24'h000018;
    localparam logic [23:0] ADDR_ERR_TALLY = 24'h00001c;

    // ==========================================================
    // field positions
    localparam int IFC_XIP_BIT = 4;
    localparam int IFC_LAT_MSB = 3;
    localparam int LAT_W = 4;
    localparam int INT_FLAG_BIT = 7;
    localparam int INT_IRQ_CLR_BIT = 6;
    localparam int INT_TALLY_CLR_BIT = 5;
    localparam int INT_DIE_MSB = 3;
    localparam int INT_DIE_LSB = 2;
    localparam int INT_TEST_BIT = 1;
    localparam int INT_ROUTE_BIT = 0;

    // ==========================================================
    // reset values
    localparam logic [4:0] IFC_CFG_RST = 5'h08;
    localparam logic [3:0] INT_CFG_RST = 4'h0;
    localparam int ECC_W = 32;
    localparam logic [31:0] WORD_RST = 32'h00000000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } mliet_wr_type;

    typedef struct packed {
        logic [31:0] word;
        logic corrected;
        logic uncorrectable;
    } mliet_ecc_res_type;

endpackage : mliet_pkg

// [src/mliet_ecc_engine.sv]
// secded test engine: injects the flip mask and decodes the result word
`timescale 1ns/1ps

module mliet_ecc_engine
    import mliet_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic [ECC_W-1:0] data_i,
    input wire logic [ECC_W-1:0] mask_i,
    output mliet_ecc_res_type res_o,
    output logic done_o
);

    // position of a data bit inside the hamming code word
    function automatic logic [5:0] data_pos(input int idx);
        int n;
        int p;
        n = -1;
        p = 0;
        for (int k = 1; k < 64; k++) begin
            if (((k & (k - 1)) != 0) && (n < idx)) begin
                n = n + 1;
                p = k;
            end
        end
        return p[5:0];
    endfunction : data_pos

    // ==========================================================
    // check bits of the clean and of the corrupted buffer
    logic [ECC_W-1:0] buf_w;
    logic [5:0] chk_clean;
    logic [5:0] chk_dirty;
    logic [5:0] syn_w;
    logic [ECC_W-1:0] hit_w;
    logic odd_w;
    logic single_w;
    logic bad_w;
    logic [ECC_W-1:0] fixed_w;

    assign buf_w = data_i ^ mask_i;

    always_comb begin
        chk_clean = 6'h00;
        chk_dirty = 6'h00;
        for (int i = 0; i < ECC_W; i++) begin
            if (data_i[i]) begin
                chk_clean = chk_clean ^ data_pos(i);
            end
            if (buf_w[i]) begin
                chk_dirty = chk_dirty ^ data_pos(i);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < ECC_W; g++) begin : g_hit
            assign hit_w[g] = (syn_w == data_pos(g));
        end
    endgenerate

    assign syn_w = chk_clean ^ chk_dirty;
    assign odd_w = (^data_i) ^ (^buf_w);
    assign single_w = odd_w && (syn_w != 6'h00) && (|hit_w);
    assign bad_w = ((syn_w != 6'h00) || odd_w) && !single_w;
    assign fixed_w = single_w ? (buf_w ^ hit_w) : buf_w;

    // ==========================================================
    // registered result
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            res_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= start_i;
            if (start_i) begin
                res_o <= '{word: fixed_w, corrected: single_w, uncorrectable: bad_w};
            end
        end
    end

endmodule : mliet_ecc_engine

// [tb/mliet_regs_asserts.sv]
// concurrent checks on the register bank pins
`timescale 1ns/1ps

module mliet_regs_asserts
    import mliet_pkg::*;
#(
    parameter bit READY_IRQ_EN = 1'b1
)(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic ecc_corrected_i,
    input wire logic ecc_uncorrectable_i,
    input wire logic dev_ready_i,
    input wire logic int_n_o,
    input wire logic execute_in_place_write_block_o,
    input wire logic [LAT_W-1:0] read_wait_cycles_o,
    input wire logic ecc_selftest_on_o,
    input wire logic [1:0] die_select_o,
    input wire logic write_enable_latch_o
);
    // ==========================================================
    // ages in core cycles since the write enable latch last fell (accepted write or write disable) and since the last frame
    logic rdy_r;
    logic wel_r;
    logic [3:0] wr_age_r;
    logic [3:0] cs_age_r;
    wire ev = ecc_corrected_i | ecc_uncorrectable_i | (dev_ready_i & ~rdy_r);
    wire wr_done = wel_r & ~write_enable_latch_o;
    always_ff @(posedge core_clk_i) begin
        rdy_r <= dev_ready_i;
        wel_r <= write_enable_latch_o;
        wr_age_r <= sys_rst_i ? 4'hf : wr_done ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hf};
        cs_age_r <= (sys_rst_i | ~cs_n_i) ? 4'h0 : cs_age_r + {3'h0, cs_age_r != 4'hf};
    end

    // ==========================================================
    // assertions
    reset_vals_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> read_wait_cycles_o == 4'h8 && !execute_in_place_write_block_o
        && !ecc_selftest_on_o && !write_enable_latch_o && int_n_o)
        else $error("config pins off reset values");
    irq_cause_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(int_n_o) |-> $past(ev) || $past(ev, 2) || $past(ev, 3) || ecc_selftest_on_o)
        else $error("interrupt fell without an event");
    irq_release_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(int_n_o) |-> ##[0:3] wr_age_r < 4'h6)
        else $error("interrupt released without a write");
    cfg_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $changed({execute_in_place_write_block_o, read_wait_cycles_o, ecc_selftest_on_o,
        die_select_o}) |-> ##[0:3] wr_age_r < 4'h6)
        else $error("config changed without a write");
    latch_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(write_enable_latch_o) |-> cs_age_r < 4'ha)
        else $error("latch set without a frame");
    ready_irq_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        READY_IRQ_EN && dev_ready_i && !rdy_r |-> ##[1:3] !int_n_o)
        else $error("ready edge gave no interrupt");
    so_idle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        cs_n_i && $past(cs_n_i) |-> !so_oe_o && !so_o)
        else $error("serial out driven while deselected");
    so_burst_a: assert property (@(negedge sck_i) disable iff (sys_rst_i)
        $rose(so_oe_o) |-> so_oe_o [*8] ##1 !so_oe_o)
        else $error("read burst not eight bits");
endmodule : mliet_regs_asserts

// [tb/mliet_host.sv]
// host serial controller model issuing register commands
`timescale 1ns/1ps

module mliet_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    // ==========================================================
    // mode 0, msb first, 32 ns bit clock idling low between frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    task automatic tick(input logic b, output logic s);
        si_o = b;
        #16 sck_o = 1'b1;
        s = so_i;
        #16 sck_o = 1'b0;
    endtask : tick

    task automatic idle_clk();
        logic s;
        tick(si_o, s);
        tick(si_o, s);
    endtask : idle_clk

    task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input int n,
                         input logic [7:0] wd, output logic [7:0] rd);
        logic [71:0] sh;
        logic s;
        sh = {cmd, a, wd, 32'h0};
        rd = 8'h00;
        #7 cs_n_o = 1'b0;
        #9;
        for (int k = 0; k < n; k++) begin
            tick(sh[71-k], s);
            rd = {rd[6:0], s};
        end
        #16 cs_n_o = 1'b1;
        si_o = ~si_o;
        #240;
    endtask : frame
endmodule : mliet_host

// [tb/mliet_regs_test.sv]
// self-checking bench for the configuration, interrupt and ecc test bank
`timescale 1ns/1ps

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module mliet_regs_test;
    import mliet_pkg::*;
    logic core_clk_i;
    logic sys_rst_i;
    logic ecc_corrected_i;
    logic ecc_uncorrectable_i;
    logic dev_ready_i;
    wire sck, cs_n, si, so, so_oe, int_n, xip, test_on, wel;
    wire [3:0] lat_o;
    wire [1:0] die;
    int n_errors = 0;
    int check_count = 0;
    int lat = 8;
    int i;
    int k;
    logic [7:0] b;
    logic [7:0] sink;
    logic [31:0] w, d, m;

    mliet_regs uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck),
        .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .ecc_corrected_i(ecc_corrected_i), .ecc_uncorrectable_i(ecc_uncorrectable_i),
        .dev_ready_i(dev_ready_i), .int_n_o(int_n), .execute_in_place_write_block_o(xip),
        .read_wait_cycles_o(lat_o), .ecc_selftest_on_o(test_on), .die_select_o(die),
        .write_enable_latch_o(wel));
    mliet_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so));

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic wr(input logic [23:0] a, input logic [7:0] v);
        host.frame(CMD_WRITE_ENABLE_LATCH, 24'h0, 8, 8'h00, sink);
        host.frame(CMD_WRAR, a, 40, v, sink);
    endtask : wr
    task automatic rd(input logic [23:0] a, output logic [7:0] v);
        host.frame(CMD_RDAR, a, 40 + lat, 8'h00, v);
    endtask : rd
    task automatic wr32(input logic [23:0] a, input logic [31:0] v);
        for (int j = 0; j < 4; j++) wr(a + 24'(j), v[8*j +: 8]);
    endtask : wr32
    task automatic rd32(input logic [23:0] a, output logic [31:0] v);
        for (int j = 0; j < 4; j++) rd(a + 24'(j), v[8*j +: 8]);
    endtask : rd32
    task automatic pulse(input logic unc);
        @(negedge core_clk_i);
        ecc_corrected_i = !unc;
        ecc_uncorrectable_i = unc;
        @(negedge core_clk_i);
        ecc_corrected_i = 1'b0;
        ecc_uncorrectable_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
    endtask : pulse
    function automatic logic uncorr(input logic [31:0] mk);
        return $countones(mk) > 1;
    endfunction : uncorr

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial begin
        #2000000;
        n_errors++;
        close_out();
    end

    initial begin
        sys_rst_i = 1'b1;
        ecc_corrected_i = 1'b0;
        ecc_uncorrectable_i = 1'b0;
        dev_ready_i = 1'b0;
        void'($urandom(83));
        fork
            repeat (10) @(negedge core_clk_i);
            repeat (2) host.idle_clk();
        join
        sys_rst_i = 1'b0;
        host.idle_clk();
        `CHK(lat_o, 4'h8)
        `CHK({xip, test_on, die, wel, int_n}, 6'h01)
        wr(ADDR_IFC_CFG, 8'h0c);
        lat = 12;
        for (i = 0; i < 4; i++) begin
            rd32(ADDR_ECC_DIN + 24'(4 * i), w);
            `CHK(w, WORD_RST)
        end
        $display("test reset done");
        host.frame(CMD_WRAR, ADDR_IFC_CFG, 40, 8'hff, sink);
        rd(ADDR_IFC_CFG, b);
        `CHK(b, 8'h0c)
        host.frame(CMD_WRITE_ENABLE_LATCH, 24'h0, 8, 8'h00, sink);
        `CHK(wel, 1'b1)
        host.frame(CMD_WRAR, ADDR_IFC_CFG, 40, 8'hff, sink);
        `CHK(wel, 1'b0)
        lat = 15;
        rd(24'h000040, b);
        `CHK(b, 8'h00)
        for (i = 0; i < 6; i++) begin
            d[7:0] = 8'($urandom) | 8'h0c;
            wr(ADDR_IFC_CFG, d[7:0]);
            lat = int'(d[3:0]);
            rd(ADDR_IFC_CFG, b);
            `CHK(b, {3'h0, d[4:0]})
            `CHK({xip, lat_o}, d[4:0])
        end
        $display("test interface config done");
        for (i = 0; i < 4; i++) begin
            b = {4'hf, 2'(i), 2'b01};
            wr(ADDR_INT_CFG, b);
            `CHK(die, b[3:2])
            rd(ADDR_INT_CFG, d[7:0]);
            `CHK(d[7:0], {4'h0, b[3:0]})
        end
        pulse(1'b0);
        `CHK(int_n, 1'b0)
        wr(ADDR_INT_CFG, 8'h40);
        `CHK(int_n, 1'b1)
        pulse(1'b0);
        `CHK(int_n, 1'b1)
        @(negedge core_clk_i);
        dev_ready_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        `CHK(int_n, 1'b0)
        wr(ADDR_INT_CFG, 8'h40);
        pulse(1'b1);
        wr(ADDR_INT_CFG, 8'h00);
        rd(ADDR_INT_CFG, b);
        `CHK(b, 8'h80)
        wr(ADDR_INT_CFG, 8'h40);
        rd(ADDR_INT_CFG, b);
        `CHK({b, int_n}, 9'h001)
        $display("test interrupt done");
        for (i = 0; i < 9; i++) begin
            k = (i == 2) ? 0 : $urandom_range(30);
            d = $urandom;
            m = ((i % 3 == 0) ? 32'h0 : (i % 3 == 1) ? 32'h1 : 32'h3) << k;
            repeat (2) wr(ADDR_INT_CFG, {4'h6, 2'(i), 2'b01});
            wr32(ADDR_ECC_DIN, d);
            wr32(ADDR_ECC_MASK, m);
            wr(ADDR_INT_CFG, {4'h0, 2'(i), 2'b11});
            `CHK(test_on, 1'b1)
            rd32(ADDR_ECC_OUT, w);
            if (!uncorr(m)) `CHK(w, d)
            rd32(ADDR_ERR_TALLY, w);
            `CHK(w, {31'h0, uncorr(m)})
            rd(ADDR_INT_CFG, b);
            `CHK(b, {uncorr(m), 3'h0, 2'(i), 2'b11})
            if (uncorr(m)) `CHK(int_n, 1'b0)
        end
        repeat (2) wr(ADDR_INT_CFG, 8'h60);
        rd32(ADDR_ERR_TALLY, w);
        `CHK(w, WORD_RST)
        `CHK({test_on, int_n}, 2'b01)
        $display("test ecc engine done");
        close_out();
    end
endmodule : mliet_regs_test

bind mliet_regs mliet_regs_asserts #(.READY_IRQ_EN(READY_IRQ_EN)) chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .ecc_corrected_i(ecc_corrected_i),
    .ecc_uncorrectable_i(ecc_uncorrectable_i), .dev_ready_i(dev_ready_i),
    .int_n_o(int_n_o), .execute_in_place_write_block_o(execute_in_place_write_block_o),
    .read_wait_cycles_o(read_wait_cycles_o), .ecc_selftest_on_o(ecc_selftest_on_o),
    .die_select_o(die_select_o), .write_enable_latch_o(write_enable_latch_o));
